// ===== logic/fcih_host.sv
// apb controlled host that drives the flash command interface
// How it works
// - raise strobe between status reads
// - erase is setup then confirm in block
// - never output and write strobe together
// - issue only defined command codes
// - clear status before retrying failed erase; software issues the clear with OP_CLEAR_STATUS
`timescale 1ns/10ps
module fcih_host (
   // clock and reset
   input wire logic clk,
   input wire logic rst_n,
   // apb slave
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   // flash pins
   output logic chipSelectN,
   output logic outputEnableN,
   output logic writeStrobeN,
   output logic [17:0] flashAddr,
   output logic [15:0] dataOut,
   output logic dataOeN,
   input wire logic [15:0] dataIn,
   input wire logic readyBusyIn,
   output logic bootLockPin,
   output logic highVoltageSel,
   output logic powerdownResetPinN
);
   typedef enum logic [2:0] {
      SQ_IDLE = 3'b000,
      SQ_CMD = 3'b001,
      SQ_SECOND = 3'b011,
      SQ_WAIT = 3'b010,
      SQ_POLL = 3'b110
   } fcih_sq_t;

   fcih_sq_t sq_q, sq_d;
   logic [3:0] op_q, op_d;
   logic [17:0] addr_q, addr_d;
   logic [15:0] wdata_q, wdata_d;
   logic [15:0] rdata_q, rdata_d;
   logic [7:0] devStat_q, devStat_d;
   logic [2:0] pinCtl_q, pinCtl_d;
   logic busy_q, busy_d;
   logic err_q, err_d;
   logic rbMeta_q, rbSync_q;
   logic cycStart;
   fcih_pkg::fcih_cyc_t cycReq;
   logic cycDone;
   logic [15:0] cycData;
   fcih_pkg::fcih_pins_t pins;
   logic wrAcc;
   logic [7:0] firstCode;
   logic twoCycle;

   // ready/busy pin is asynchronous to clk
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         rbMeta_q <= 1'b1;
         rbSync_q <= 1'b1;
      end else begin
         rbMeta_q <= readyBusyIn;
         rbSync_q <= rbMeta_q;
      end
   end

   fcih_bus_cycle u_cycle (
      .clk(clk),
      .rst_n(rst_n),
      .start(cycStart),
      .req(cycReq),
      .done(cycDone),
      .readData(cycData),
      .pins(pins),
      .dataIn(dataIn)
   );

   assign chipSelectN = pins.chipSelectN;
   assign outputEnableN = pins.outputEnableN;
   assign writeStrobeN = pins.writeStrobeN;
   assign flashAddr = pins.addr;
   assign dataOut = pins.dataOut;
   assign dataOeN = pins.dataOeN;
   assign bootLockPin = pinCtl_q[fcih_pkg::PINS_LOCK];
   assign highVoltageSel = pinCtl_q[fcih_pkg::PINS_HV];
   assign powerdownResetPinN = !pinCtl_q[fcih_pkg::PINS_PD];

   assign wrAcc = psel && penable && pwrite;
   assign pready = 1'b1;
   assign pslverr = 1'b0;

   // first cycle code for each operation; only defined codes
   always_comb begin
      twoCycle = 1'b0;
      case (fcih_pkg::fcih_op_t'(op_q))
         fcih_pkg::OP_READ_ARRAY: firstCode = fcih_pkg::CMD_READ_ARRAY;
         fcih_pkg::OP_READ_ID: firstCode = fcih_pkg::CMD_READ_ID;
         fcih_pkg::OP_READ_STATUS: firstCode = fcih_pkg::CMD_READ_STATUS;
         fcih_pkg::OP_CLEAR_STATUS: firstCode = fcih_pkg::CMD_CLEAR_STATUS; // clear before a retry
         fcih_pkg::OP_ERASE: begin
            firstCode = fcih_pkg::CMD_ERASE_SETUP;
            twoCycle = 1'b1;
         end
         fcih_pkg::OP_PROGRAM: begin
            firstCode = fcih_pkg::CMD_PROGRAM_SETUP;
            twoCycle = 1'b1;
         end
         fcih_pkg::OP_PROGRAM_ALT: begin
            firstCode = fcih_pkg::CMD_PROGRAM_ALT;
            twoCycle = 1'b1;
         end
         fcih_pkg::OP_SUSPEND: firstCode = fcih_pkg::CMD_SUSPEND;
         fcih_pkg::OP_RESUME: firstCode = fcih_pkg::CMD_RESUME;
         default: firstCode = fcih_pkg::CMD_READ_STATUS;
      endcase
   end

   always_comb begin
      sq_d = sq_q;
      op_d = op_q;
      addr_d = addr_q;
      wdata_d = wdata_q;
      rdata_d = rdata_q;
      devStat_d = devStat_q;
      pinCtl_d = pinCtl_q;
      busy_d = busy_q;
      err_d = err_q;
      cycStart = 1'b0;
      cycReq = '{write: 1'b1, addr: addr_q, data: {8'h00, firstCode}};
      if (wrAcc && !busy_q) begin
         case (paddr)
            fcih_pkg::REG_CTRL: begin
               if (pwdata[fcih_pkg::CTRL_GO]) begin
                  op_d = pwdata[fcih_pkg::CTRL_OP_HI:fcih_pkg::CTRL_OP_LO];
                  busy_d = 1'b1;
                  err_d = 1'b0;
                  sq_d = SQ_CMD;
               end
            end
            fcih_pkg::REG_ADDR: addr_d = pwdata[17:0];
            fcih_pkg::REG_WDATA: wdata_d = pwdata[15:0];
            fcih_pkg::REG_PINS: pinCtl_d = pwdata[2:0];
            default: ;
         endcase
      end
      case (sq_q)
         SQ_IDLE: ;
         SQ_CMD: begin
            // a plain read needs no command cycle
            cycStart = 1'b1;
            if (fcih_pkg::fcih_op_t'(op_q) == fcih_pkg::OP_READ) begin
               cycReq = '{write: 1'b0, addr: addr_q, data: 16'h0000};
            end
            sq_d = twoCycle ? SQ_SECOND : SQ_WAIT;
         end
         SQ_SECOND: begin
            if (cycDone) begin
               cycStart = 1'b1;
               // erase confirm at the same block address, bits 17..12
               if (fcih_pkg::fcih_op_t'(op_q) == fcih_pkg::OP_ERASE) begin
                  cycReq = '{write: 1'b1, addr: addr_q, data: {8'h00, fcih_pkg::CMD_CONFIRM}};
               end else begin
                  cycReq = '{write: 1'b1, addr: addr_q, data: wdata_q};
               end
               sq_d = SQ_POLL;
            end
         end
         SQ_WAIT: begin
            if (cycDone) begin
               rdata_d = cycData;
               busy_d = 1'b0;
               sq_d = SQ_IDLE;
            end
         end
         SQ_POLL: begin
            // device answers status reads after erase or program
            // status reads repeat until the busy pin shows ready
            if (cycDone) begin
               cycStart = 1'b1;
               cycReq = '{write: 1'b0, addr: addr_q, data: 16'h0000};
               if (rbSync_q) begin
                  sq_d = SQ_WAIT;
               end
            end
         end
         default: sq_d = SQ_IDLE;
      endcase
      // status captured after a busy poll; error summary from failure bits
      // only the final read of erase or program is surely a status byte
      if (sq_q == SQ_WAIT && cycDone && (op_q == 4'(fcih_pkg::OP_ERASE) || op_q == 4'(fcih_pkg::OP_PROGRAM)
          || op_q == 4'(fcih_pkg::OP_PROGRAM_ALT))) begin
         devStat_d = cycData[7:0];
         err_d = cycData[fcih_pkg::SR_ERASE_ERR] | cycData[fcih_pkg::SR_PROG_ERR]
               | cycData[fcih_pkg::SR_SUPPLY_LOW] | cycData[fcih_pkg::SR_LOCK_VIOL];
      end
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         sq_q <= SQ_IDLE;
         op_q <= 4'h0;
         addr_q <= fcih_pkg::ADDR_RST;
         wdata_q <= fcih_pkg::WDATA_RST;
         rdata_q <= 16'h0000;
         devStat_q <= 8'h00;
         pinCtl_q <= 3'h0;
         busy_q <= 1'b0;
         err_q <= 1'b0;
      end else begin
         sq_q <= sq_d;
         op_q <= op_d;
         addr_q <= addr_d;
         wdata_q <= wdata_d;
         rdata_q <= rdata_d;
         devStat_q <= devStat_d;
         pinCtl_q <= pinCtl_d;
         busy_q <= busy_d;
         err_q <= err_d;
      end
   end

   // read mux; suspend flags and lock/clear ordering stay software's job
   always_comb begin
      case (paddr)
         fcih_pkg::REG_CTRL: prdata = {24'h000000, op_q, 4'h0};
         fcih_pkg::REG_ADDR: prdata = {14'h0000, addr_q};
         fcih_pkg::REG_WDATA: prdata = {16'h0000, wdata_q};
         fcih_pkg::REG_STATUS: prdata = {29'h00000000, rbSync_q, err_q, busy_q};
         fcih_pkg::REG_RDATA: prdata = {16'h0000, rdata_q};
         fcih_pkg::REG_DEVSTAT: prdata = {24'h000000, devStat_q};
         fcih_pkg::REG_PINS: prdata = {29'h00000000, pinCtl_q};
         default: prdata = 32'h00000000;
      endcase
   end
endmodule

// ===== logic/fcih_pkg.sv
// shared constants and types of the flash command host controller
package fcih_pkg;
   // command codes written to the device
   localparam logic [7:0] CMD_READ_ARRAY = 8'hff;
   localparam logic [7:0] CMD_READ_ID = 8'h90;
   localparam logic [7:0] CMD_READ_STATUS = 8'h70;
   localparam logic [7:0] CMD_CLEAR_STATUS = 8'h50;
   localparam logic [7:0] CMD_ERASE_SETUP = 8'h20;
   localparam logic [7:0] CMD_CONFIRM = 8'hd0;
   localparam logic [7:0] CMD_PROGRAM_SETUP = 8'h40;
   localparam logic [7:0] CMD_PROGRAM_ALT = 8'h10;
   localparam logic [7:0] CMD_SUSPEND = 8'hb0;
   localparam logic [7:0] CMD_RESUME = 8'hd0;
   // identifier addresses
   localparam logic [17:0] ID_ADDR_MAKER = 18'h00000;
   localparam logic [17:0] ID_ADDR_DEVICE = 18'h00001;
   // status byte field positions
   localparam int SR_READY = 7;
   localparam int SR_ERASE_SUSP = 6;
   localparam int SR_ERASE_ERR = 5;
   localparam int SR_PROG_ERR = 4;
   localparam int SR_SUPPLY_LOW = 3;
   localparam int SR_PROG_SUSP = 2;
   localparam int SR_LOCK_VIOL = 1;
   // block select field of the address
   localparam int BLOCK_HI = 17;
   localparam int BLOCK_LO = 12;
   // own register byte offsets on apb
   localparam logic [7:0] REG_CTRL = 8'h00;
   localparam logic [7:0] REG_ADDR = 8'h04;
   localparam logic [7:0] REG_WDATA = 8'h08;
   localparam logic [7:0] REG_STATUS = 8'h0c;
   localparam logic [7:0] REG_RDATA = 8'h10;
   localparam logic [7:0] REG_DEVSTAT = 8'h14;
   localparam logic [7:0] REG_PINS = 8'h18;
   // control register fields
   localparam int CTRL_GO = 0;
   localparam int CTRL_OP_LO = 4;
   localparam int CTRL_OP_HI = 7;
   // pin control register fields
   localparam int PINS_LOCK = 0;
   localparam int PINS_HV = 1;
   localparam int PINS_PD = 2;
   // reset values
   localparam logic [15:0] WDATA_RST = 16'h0000;
   localparam logic [17:0] ADDR_RST = 18'h00000;
   // bus cycle timing in ns and cycles at 40 MHz
   localparam int CLK_NS = 25;
   localparam int STROBE_NS = 60;
   localparam int GAP_NS = 30;
   localparam int STROBE_CYC = (STROBE_NS + CLK_NS - 1) / CLK_NS;
   localparam int GAP_CYC = (GAP_NS + CLK_NS - 1) / CLK_NS;
   localparam logic [3:0] STROBE_CNT = 4'(STROBE_CYC);
   localparam logic [3:0] GAP_CNT = 4'(GAP_CYC);

   // operations software may ask for
   typedef enum logic [3:0] {
      OP_READ_ARRAY = 4'h0,
      OP_READ_ID = 4'h1,
      OP_READ_STATUS = 4'h2,
      OP_CLEAR_STATUS = 4'h3,
      OP_ERASE = 4'h4,
      OP_PROGRAM = 4'h5,
      OP_SUSPEND = 4'h6,
      OP_RESUME = 4'h7,
      OP_READ = 4'h8,
      OP_PROGRAM_ALT = 4'h9
   } fcih_op_t;

   // one bus cycle request to the pin engine
   typedef struct packed {
      logic write;
      logic [17:0] addr;
      logic [15:0] data;
   } fcih_cyc_t;

   // device side pins driven by the controller
   typedef struct packed {
      logic chipSelectN;
      logic outputEnableN;
      logic writeStrobeN;
      logic [17:0] addr;
      logic [15:0] dataOut;
      logic dataOeN;
   } fcih_pins_t;
endpackage

// ===== logic/fcih_bus_cycle.sv
// one timed read or write cycle on the flash pins
`timescale 1ns/10ps
module fcih_bus_cycle (
   // clock and reset
   input wire logic clk,
   input wire logic rst_n,
   // request from the sequencer
   input wire logic start,
   input wire fcih_pkg::fcih_cyc_t req,
   output logic done,
   output logic [15:0] readData,
   // pins toward the device
   output fcih_pkg::fcih_pins_t pins,
   input wire logic [15:0] dataIn
);
   typedef enum logic [1:0] {
      CY_IDLE = 2'b00,
      CY_STROBE = 2'b01,
      CY_GAP = 2'b11
   } fcih_cy_t;

   fcih_cy_t state_q, state_d;
   logic [3:0] cnt_q, cnt_d;
   fcih_pkg::fcih_pins_t pins_q, pins_d;
   logic [15:0] rdata_q, rdata_d;
   logic [15:0] dinMeta_q, dinSync_q;

   // data pins come from outside the clock domain
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         dinMeta_q <= 16'h0000;
         dinSync_q <= 16'h0000;
      end else begin
         dinMeta_q <= dataIn;
         dinSync_q <= dinMeta_q;
      end
   end

   always_comb begin
      state_d = state_q;
      cnt_d = cnt_q;
      pins_d = pins_q;
      rdata_d = rdata_q;
      done = 1'b0;
      case (state_q)
         CY_IDLE: ;
         CY_STROBE: begin
            if (cnt_q != 4'h0) begin
               cnt_d = cnt_q - 4'h1;
            end else begin
               // strobes rise together; data stays driven past the edge
               rdata_d = dinSync_q;
               pins_d.chipSelectN = 1'b1;
               pins_d.outputEnableN = 1'b1;
               pins_d.writeStrobeN = 1'b1;
               cnt_d = fcih_pkg::GAP_CNT;
               state_d = CY_GAP;
            end
         end
         CY_GAP: begin
            // strobes stay high so the next status read relatches
            pins_d.dataOeN = 1'b1;
            if (cnt_q != 4'h0) begin
               cnt_d = cnt_q - 4'h1;
            end else begin
               done = 1'b1;
               state_d = CY_IDLE;
            end
         end
         default: state_d = CY_IDLE;
      endcase
      // a request may follow the gap at once, or a start raised with done is lost
      if (start && (state_q == CY_IDLE || done)) begin
         // never both strobes low: only one is asserted per cycle
         pins_d.chipSelectN = 1'b0;
         pins_d.outputEnableN = req.write;
         pins_d.writeStrobeN = !req.write;
         pins_d.addr = req.addr;
         pins_d.dataOut = req.data;
         pins_d.dataOeN = !req.write;
         cnt_d = fcih_pkg::STROBE_CNT;
         state_d = CY_STROBE;
      end
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         state_q <= CY_IDLE;
         cnt_q <= 4'h0;
         pins_q <= '{chipSelectN: 1'b1, outputEnableN: 1'b1, writeStrobeN: 1'b1,
                     addr: fcih_pkg::ADDR_RST, dataOut: fcih_pkg::WDATA_RST, dataOeN: 1'b1};
         rdata_q <= 16'h0000;
      end else begin
         state_q <= state_d;
         cnt_q <= cnt_d;
         pins_q <= pins_d;
         rdata_q <= rdata_d;
      end
   end

   assign pins = pins_q;
   assign readData = rdata_q;
endmodule

// ===== testbench/fcih_host_props.sv
// pin timing and apb answer checks of the flash host
`timescale 1ns/10ps
module fcih_host_props (
   // clock and reset
   input wire logic clk,
   input wire logic rst_n,
   // apb
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic [31:0] prdata,
   input wire logic pready,
   input wire logic pslverr,
   // flash pins
   input wire logic chipSelectN,
   input wire logic outputEnableN,
   input wire logic writeStrobeN,
   input wire logic [17:0] flashAddr,
   input wire logic [15:0] dataOut,
   input wire logic dataOeN,
   input wire logic bootLockPin,
   input wire logic highVoltageSel,
   input wire logic powerdownResetPinN
);
   default clocking @(posedge clk); endclocking
   default disable iff (!rst_n);
   property p_no_fight; !(!outputEnableN && !writeStrobeN); endproperty
   a_no_fight: assert property (p_no_fight) else $error("oe and we low together");
   property p_bus_free; !dataOeN |-> outputEnableN; endproperty
   a_bus_free: assert property (p_bus_free) else $error("data driven during read");
   property p_we_cs; !writeStrobeN |-> !chipSelectN; endproperty
   a_we_cs: assert property (p_we_cs) else $error("write strobe without select");
   property p_wr_hold; $rose(writeStrobeN) |-> $stable(flashAddr) && $stable(dataOut) && !$past(dataOeN); endproperty
   a_wr_hold: assert property (p_wr_hold) else $error("write data moved at strobe rise");
   property p_we_len; $fell(writeStrobeN) |-> !writeStrobeN [*4]; endproperty
   a_we_len: assert property (p_we_len) else $error("write strobe too short");
   property p_oe_gap; $rose(outputEnableN) |-> outputEnableN [*2]; endproperty
   a_oe_gap: assert property (p_oe_gap) else $error("read strobe gap too short");
   property p_oe_cs; $fell(outputEnableN) |-> !chipSelectN; endproperty
   a_oe_cs: assert property (p_oe_cs) else $error("read strobe without select");
   property p_pins;
      psel && penable && pwrite && paddr == fcih_pkg::REG_PINS |=> bootLockPin == $past(pwdata[0]) &&
         highVoltageSel == $past(pwdata[1]) && powerdownResetPinN != $past(pwdata[2]);
   endproperty
   a_pins: assert property (p_pins) else $error("pin register not on pins");
   property p_apb; psel && penable |-> pready && !pslverr; endproperty
   a_apb: assert property (p_apb) else $error("apb answer wrong");
   property p_unmapped; psel && !pwrite && paddr > 8'h18 |-> prdata == 32'h0; endproperty
   a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");
endmodule

bind fcih_host fcih_host_props i_fcih_host_props (.clk, .rst_n, .psel, .penable, .pwrite, .paddr, .pwdata,
   .prdata, .pready, .pslverr, .chipSelectN, .outputEnableN, .writeStrobeN, .flashAddr, .dataOut, .dataOeN,
   .bootLockPin, .highVoltageSel, .powerdownResetPinN);

// ===== testbench/fcih_flash_model.sv
// behavioural flash device behind the host controller
`timescale 1ns/10ps
module fcih_flash_model #(
   parameter logic [7:0] MAKER_CODE = 8'h3c,
   parameter logic [7:0] DEVICE_CODE = 8'h5a,
   parameter logic [5:0] BOOT_BLK = 6'h3f,
   parameter int BUSY_NS = 400
) (
   // pins from host
   input wire logic chipSelectN,
   input wire logic outputEnableN,
   input wire logic writeStrobeN,
   input wire logic [17:0] flashAddr,
   input wire logic [15:0] dataOut,
   input wire logic bootLockPin,
   input wire logic highVoltageSel,
   input wire logic powerdownResetPinN,
   input wire logic supplyLow,
   // pins to host
   output logic [15:0] dataIn,
   output logic readyBusyIn
);
   logic [15:0] mem [0:262143];
   logic [7:0] sr = 8'h80;
   logic [7:0] srLat = 8'h80;
   logic [7:0] pend = 8'h00;
   logic [1:0] mode = 2'd0;
   logic [15:0] rd;
   logic [15:0] last = 16'h0000;
   logic busy = 1'b0;
   logic act = 1'b0;
   initial begin
      foreach (mem[i]) mem[i] = 16'hffff;
   end
   assign readyBusyIn = !busy || !powerdownResetPinN;
   always @(negedge powerdownResetPinN) mode = 2'd0;
   task automatic kick;
      busy = 1'b1;
      sr[7] = 1'b0;
      fork
         begin
            #BUSY_NS;
            busy = 1'b0;
            sr[7] = 1'b1;
         end
      join_none
   endtask
   task automatic wr(input logic [17:0] a, input logic [15:0] d);
      logic lk;
      logic [7:0] p;
      lk = a[17:12] == BOOT_BLK && !bootLockPin && !highVoltageSel;
      p = pend;
      if (busy) begin
         if (d[7:0] == fcih_pkg::CMD_READ_STATUS) mode = 2'd2;
      end else if (p != 8'h00) begin
         pend = 8'h00;
         mode = 2'd2;
         if (p == fcih_pkg::CMD_ERASE_SETUP && d[7:0] != fcih_pkg::CMD_CONFIRM) sr |= 8'h30;
         else if (supplyLow) sr |= (p == fcih_pkg::CMD_ERASE_SETUP) ? 8'h28 : 8'h18;
         else if (lk) sr |= (p == fcih_pkg::CMD_ERASE_SETUP) ? 8'h22 : 8'h12;
         else begin
            if (p == fcih_pkg::CMD_ERASE_SETUP) for (int i = 0; i < 4096; i++) mem[{a[17:12], 12'(i)}] = 16'hffff;
            else mem[a] = d;
            kick();
         end
      end else begin
         case (d[7:0])
            fcih_pkg::CMD_READ_ARRAY: mode = 2'd0;
            fcih_pkg::CMD_READ_ID: mode = 2'd1;
            fcih_pkg::CMD_READ_STATUS: mode = 2'd2;
            fcih_pkg::CMD_CLEAR_STATUS: sr &= 8'hc5;
            fcih_pkg::CMD_ERASE_SETUP, fcih_pkg::CMD_PROGRAM_SETUP, fcih_pkg::CMD_PROGRAM_ALT: pend = d[7:0];
            default: ;
         endcase
      end
   endtask
   // command taken when the first of the two strobes rises
   always @(writeStrobeN or chipSelectN) begin
      if (!writeStrobeN && !chipSelectN) act = 1'b1;
      else if (act) begin
         act = 1'b0;
         wr(flashAddr, dataOut);
      end
   end
   always @(negedge outputEnableN) srLat = sr;
   always @* begin
      if (mode == 2'd2) rd = {8'h00, srLat};
      else if (mode == 2'd1) rd = {8'h00, (flashAddr == fcih_pkg::ID_ADDR_DEVICE) ? DEVICE_CODE : MAKER_CODE};
      else rd = mem[flashAddr];
   end
   // released bus shows the inverse so a stale capture cannot pass
   always @(posedge outputEnableN) last = rd;
   assign dataIn = (!chipSelectN && !outputEnableN) ? rd : ~last;
endmodule

// ===== testbench/tb_fcih_host.sv
// self-checking bench of the flash host controller
`timescale 1ns/10ps
module tb_fcih_host;
   localparam logic [7:0] MAKER = 8'h3c; // arbitrary value
   localparam logic [7:0] DEVICE = 8'h5a; // arbitrary value
   logic clk = 1'b0;
   logic rst_n = 1'b0;
   logic psel = 1'b0;
   logic penable = 1'b0;
   logic pwrite = 1'b0;
   logic [7:0] paddr = 8'h00;
   logic [31:0] pwdata = 32'h0;
   logic [31:0] prdata;
   logic pready, pslverr, chipSelectN, outputEnableN, writeStrobeN, dataOeN;
   logic readyBusyIn, bootLockPin, highVoltageSel, powerdownResetPinN;
   logic [17:0] flashAddr;
   logic [15:0] dataOut, dataIn;
   logic supplyLow = 1'b0;
   int num_errors = 0;
   int total_checks = 0;
   int seed = 32'h6906b16e;
   logic [31:0] r;
   logic [17:0] a [4];
   logic [15:0] d [4];
   always #12.5 clk = ~clk;
   fcih_host i_fcih_host (.clk, .rst_n, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
      .chipSelectN, .outputEnableN, .writeStrobeN, .flashAddr, .dataOut, .dataOeN, .dataIn, .readyBusyIn,
      .bootLockPin, .highVoltageSel, .powerdownResetPinN);
   fcih_flash_model #(.MAKER_CODE(MAKER), .DEVICE_CODE(DEVICE)) i_fcih_flash_model (.chipSelectN, .outputEnableN,
      .writeStrobeN, .flashAddr, .dataOut, .bootLockPin, .highVoltageSel, .powerdownResetPinN, .supplyLow,
      .dataIn, .readyBusyIn);
   task tally_and_finish;
      $display("checks %0d mismatches %0d", total_checks, num_errors);
      if (num_errors == 0 && total_checks > 0) $display("TEST PASSED");
      else $display("TEST FAILED");
      $finish;
   endtask
   task chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
      total_checks++;
      if (got !== exp) begin
         $display("Error %s expected %h seen %h", nm, exp, got);
         num_errors++;
      end
   endtask
   task apb(input logic w, input logic [7:0] ad, input logic [31:0] wd);
      int n;
      n = 0;
      @(posedge clk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= ad;
      pwdata <= wd;
      @(posedge clk);
      penable <= 1'b1;
      do begin
         @(posedge clk);
         n++;
      end while (pready !== 1'b1 && n < 20);
      r = prdata;
      psel <= 1'b0;
      penable <= 1'b0;
      if (pready !== 1'b1) begin
         num_errors++;
         tally_and_finish();
      end
   endtask
   // busy is polled; the device time is not assumed
   task op(input logic [3:0] o, input logic [17:0] ad, input logic [15:0] wd);
      int n;
      n = 0;
      apb(1'b1, fcih_pkg::REG_ADDR, 32'(ad));
      apb(1'b1, fcih_pkg::REG_WDATA, 32'(wd));
      apb(1'b1, fcih_pkg::REG_CTRL, {24'h0, o, 4'h1});
      do begin
         apb(1'b0, fcih_pkg::REG_STATUS, 32'h0);
         n++;
      end while (r[0] !== 1'b0 && n < 500);
      if (r[0] !== 1'b0) begin
         num_errors++;
         tally_and_finish();
      end
   endtask
   task rdw(input logic [17:0] ad, input logic [31:0] e);
      op(fcih_pkg::OP_READ, ad, 16'h0);
      apb(1'b0, fcih_pkg::REG_RDATA, 32'h0);
      chk("rdata", e, r);
   endtask
   task sts(input logic [31:0] e);
      apb(1'b0, fcih_pkg::REG_DEVSTAT, 32'h0);
      chk("devstat", e, r);
   endtask
   function logic [31:0] exp_stat(input logic er, input logic low, input logic lk);
      exp_stat = 32'h80 | (low ? (er ? 32'h28 : 32'h18) : lk ? (er ? 32'h22 : 32'h12) : 32'h0);
   endfunction
   initial begin
      repeat (12) @(posedge clk);
      rst_n <= 1'b1;
      @(posedge clk);
      chk("reset pins", 32'h3, 32'({powerdownResetPinN, writeStrobeN}));
      rdw(18'h01234, 32'hffff);
      apb(1'b0, 8'h40, 32'h0);
      chk("unmapped", 32'h0, r);
      op(fcih_pkg::OP_READ_ID, 18'h0, 16'h0);
      rdw(fcih_pkg::ID_ADDR_MAKER, 32'(MAKER));
      rdw(fcih_pkg::ID_ADDR_DEVICE, 32'(DEVICE));
      $display("test reset and identifier done");
      for (int i = 0; i < 4; i++) begin
         a[i] = {6'(i + 1), 12'($random(seed))};
         d[i] = 16'($random(seed));
         op(i[0] ? fcih_pkg::OP_PROGRAM_ALT : fcih_pkg::OP_PROGRAM, a[i], d[i]);
         sts(exp_stat(1'b0, 1'b0, 1'b0));
         apb(1'b0, fcih_pkg::REG_STATUS, 32'h0);
         chk("status", 32'h4, r);
         op(fcih_pkg::OP_READ_ARRAY, 18'h0, 16'h0);
         rdw(a[i], 32'(d[i]));
      end
      op(fcih_pkg::OP_READ_STATUS, 18'h0, 16'h0);
      rdw(18'h0, 32'h80);
      $display("test program done");
      op(fcih_pkg::OP_ERASE, a[3], 16'h0);
      sts(exp_stat(1'b0, 1'b0, 1'b0));
      rdw(a[3], 32'h80);
      op(fcih_pkg::OP_READ_ARRAY, 18'h0, 16'h0);
      rdw(a[3], 32'hffff);
      rdw(a[2], 32'(d[2]));
      supplyLow <= 1'b1;
      op(fcih_pkg::OP_ERASE, a[2], 16'h0);
      sts(exp_stat(1'b1, 1'b1, 1'b0));
      op(fcih_pkg::OP_PROGRAM, a[1], ~d[1]);
      sts(exp_stat(1'b1, 1'b1, 1'b0) | exp_stat(1'b0, 1'b1, 1'b0));
      apb(1'b0, fcih_pkg::REG_STATUS, 32'h0);
      chk("status", 32'h6, r);
      supplyLow <= 1'b0;
      op(fcih_pkg::OP_READ_ARRAY, 18'h0, 16'h0);
      rdw(a[1], 32'(d[1]));
      rdw(a[2], 32'(d[2]));
      op(fcih_pkg::OP_CLEAR_STATUS, 18'h0, 16'h0);
      op(fcih_pkg::OP_READ_STATUS, 18'h0, 16'h0);
      rdw(18'h0, 32'h80);
      $display("test erase and supply done");
      for (int k = 0; k < 3; k++) begin
         apb(1'b1, fcih_pkg::REG_PINS, 32'(k));
         op(fcih_pkg::OP_CLEAR_STATUS, 18'h0, 16'h0);
         op(fcih_pkg::OP_ERASE, {6'h3f, 12'($random(seed))}, 16'h0);
         sts(exp_stat(k == 0, 1'b0, k == 0));
      end
      apb(1'b1, fcih_pkg::REG_PINS, 32'h4);
      // the pin register updates at the edge that takes the write
      @(posedge clk);
      chk("powerdown pins", 32'h1, 32'({powerdownResetPinN, readyBusyIn}));
      apb(1'b1, fcih_pkg::REG_PINS, 32'h0);
      rdw(a[0], 32'(d[0]));
      op(fcih_pkg::OP_SUSPEND, 18'h0, 16'h0);
      op(fcih_pkg::OP_RESUME, 18'h0, 16'h0);
      rdw(a[0], 32'(d[0]));
      $display("test boot lock and powerdown done");
      tally_and_finish();
   end
endmodule
